// file: pkg/xec_pkg.sv
package xec_pkg;
    localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
    localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;
    localparam logic [7:0] VOFS_RESET = 8'h00;
    localparam logic [7:0] VOFS_UNDEF = 8'h04;
    localparam logic [7:0] VOFS_SVC = 8'h08;
    localparam logic [7:0] VOFS_PABT = 8'h0c;
    localparam logic [7:0] VOFS_DABT = 8'h10;
    localparam logic [7:0] VOFS_RSVD = 8'h14;
    localparam logic [7:0] VOFS_IRQ = 8'h18;
    localparam logic [7:0] VOFS_FIQ = 8'h1c;
    localparam logic [31:0] RET_SUB_4 = 32'h0000_0004;
    localparam logic [31:0] RET_SUB_8 = 32'h0000_0008;
    localparam logic [31:0] RET_SUB_0 = 32'h0000_0000;
    // Fault status encodings, one per abort class
    localparam logic [4:0] FS_NONE = 5'h00;
    localparam logic [4:0] FS_ALIGN = 5'h01;
    localparam logic [4:0] FS_TRANS = 5'h05;
    localparam logic [4:0] FS_DOMAIN = 5'h09;
    localparam logic [4:0] FS_PERM = 5'h0d;
    localparam logic [4:0] FS_EXT_PRECISE = 5'h08;
    localparam logic [4:0] FS_EXT_IMPRECISE = 5'h16;
    localparam logic [4:0] FS_WATCH = 5'h02;
    localparam logic [4:0] FS_COPROC = 5'h04;
    // Memory unit fault kinds
    localparam logic [2:0] MF_ALIGN = 3'h1;
    localparam logic [2:0] MF_TRANS = 3'h2;
    localparam logic [2:0] MF_DOMAIN = 3'h3;
    localparam logic [2:0] MF_PERM = 3'h4;
    // Bus response codes
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Reset values of the masks
    localparam logic MASK_RESET = 1'b1;
    typedef enum logic [3:0] {
        XEC_NONE, XEC_RESET, XEC_DABT_P, XEC_FIQ, XEC_IRQ, XEC_DABT_I,
        XEC_PABT, XEC_BREAKPOINT_INSTR, XEC_UNDEF, XEC_SVC, XEC_DEBUG
    } xec_kind_e;
    typedef enum logic [1:0] {
        XEC_RET_NONE, XEC_RET_FIQ, XEC_RET_IRQ_ABT, XEC_RET_DABT
    } xec_ret_e;
endpackage

// file: rtl/xec_entry.sv
// What this block does
// - Fast interrupt pin is registered; logic uses only the register output
// - Fast mask clear: low registered fast request taken at instruction end
// - Fast interrupt entry sets fast and normal masks
// - Fast return target is fast link minus 4
// - Normal mask clear: low registered normal request taken at end
// - Normal interrupt ranks below fast and is masked on fast entry
// - Normal interrupt entry sets the normal and abort masks, not the fast mask
// - Normal return target is normal link minus 4
// - Abort from memory unit fault or bus slave/decode error response
// - Any abort entry sets the normal mask
// - Prefetch abort tags instruction; taken at execute, dropped on flush
// - Abort return: link minus 4 prefetch/breakpoint, minus 8 data
// - Memory unit faults and coprocessor-side aborts are precise
// - Watchpoint aborts reported at boundary before next load/store
// - External abort precise for ordered, pc/status loads, swap load
// - Cacheable external abort only if a requested word erred
// - Data abort requests restore of the base register
// - Masked imprecise abort held pending, taken once mask clears
// - Imprecise mask set on reset and abort, normal, fast entry
// - Supervisor call enters supervisor, normal masked, resumes after
// - Undefined instruction exception masks normal, resumes after
// - Breakpoint aborts at execute only; debug state if halting mode
// - Vector base zero or high by select bit
// - Fixed vector offsets per exception kind
// - Fixed priority among simultaneous exceptions
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module xec_entry (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fast_irq_in_n,
    input wire logic normal_irq_in_n,
    input wire logic instr_end,
    input wire logic vec_high_sel,
    input wire logic halt_debug_mode,
    input wire logic sw_mask_we,
    input wire logic sw_fast_mask,
    input wire logic sw_normal_mask,
    input wire logic sw_abort_mask,
    input wire logic fetch_abort,
    input wire logic decode_adv,
    input wire logic exec_adv,
    input wire logic flush,
    input wire logic exec_is_breakpoint_instr,
    input wire logic exec_is_svc,
    input wire logic exec_is_undef,
    input wire logic mmu_fault,
    input wire logic [2:0] mmu_fault_kind,
    input wire logic coproc_abort,
    input wire logic watch_hit,
    input wire logic next_is_mem,
    input wire logic bus_resp_valid,
    input wire logic [1:0] bus_resp,
    input wire logic bus_ordered,
    input wire logic bus_load_pc_status,
    input wire logic bus_swap_load,
    input wire logic bus_cacheable,
    input wire logic bus_word_requested,
    input wire logic [31:0] link_value,
    input wire logic [1:0] ret_kind,
    input wire logic ret_req,
    output logic take_exc,
    output logic [31:0] vector_addr,
    output logic [3:0] exc_kind,
    output logic fast_mask,
    output logic normal_mask,
    output logic abort_mask,
    output logic [4:0] fault_status,
    output logic base_restore,
    output logic abort_pending,
    output logic debug_enter,
    output logic [31:0] return_pc,
    output logic hold_mem
);
    logic fiq_q, irq_q;
    logic f_q, i_q, a_q;
    logic dec_bad_q, exe_bad_q;
    logic pend_q, watch_q;
    logic dabt_p;
    logic imp_err;
    logic [4:0] fs_p;
    logic take_q;
    logic [31:0] vec_q, ret_q;
    logic [3:0] kind_q;
    logic [4:0] fs_q;
    logic rest_q, dbg_q;
    xec_pkg::xec_kind_e kind_d;

    function automatic logic [4:0] mmu_fs(input logic [2:0] k);
        case (k)
            xec_pkg::MF_ALIGN: mmu_fs = xec_pkg::FS_ALIGN;
            xec_pkg::MF_TRANS: mmu_fs = xec_pkg::FS_TRANS;
            xec_pkg::MF_DOMAIN: mmu_fs = xec_pkg::FS_DOMAIN;
            default: mmu_fs = xec_pkg::FS_PERM;
        endcase
    endfunction

    function automatic logic [7:0] vofs(input xec_pkg::xec_kind_e k);
        case (k)
            xec_pkg::XEC_UNDEF: vofs = xec_pkg::VOFS_UNDEF;
            xec_pkg::XEC_SVC: vofs = xec_pkg::VOFS_SVC;
            xec_pkg::XEC_PABT, xec_pkg::XEC_BREAKPOINT_INSTR: vofs = xec_pkg::VOFS_PABT;
            xec_pkg::XEC_DABT_P, xec_pkg::XEC_DABT_I: vofs = xec_pkg::VOFS_DABT;
            xec_pkg::XEC_IRQ: vofs = xec_pkg::VOFS_IRQ;
            xec_pkg::XEC_FIQ: vofs = xec_pkg::VOFS_FIQ;
            default: vofs = xec_pkg::VOFS_RESET;
        endcase
    endfunction

    // Pins sampled once; below, only AST_FIQ_PIN_LAT reads a raw pin
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fiq_q <= 1'b1;
            irq_q <= 1'b1;
        end else begin
            fiq_q <= fast_irq_in_n;
            irq_q <= normal_irq_in_n;
        end
    end

    // Abort classification: memory unit fault, coprocessor abort, bus error
    always_comb begin
        dabt_p = 1'b0;
        imp_err = 1'b0;
        fs_p = xec_pkg::FS_NONE;
        if (mmu_fault) begin
            dabt_p = 1'b1;
            fs_p = mmu_fs(mmu_fault_kind);
        end else if (coproc_abort) begin
            dabt_p = 1'b1;
            fs_p = xec_pkg::FS_COPROC;
        end else if (bus_resp_valid && bus_resp[1]
                     && (!bus_cacheable || bus_word_requested)) begin
            if (bus_ordered || bus_load_pc_status || bus_swap_load) begin
                dabt_p = 1'b1;
                fs_p = xec_pkg::FS_EXT_PRECISE;
            end else begin
                imp_err = 1'b1;
            end
        end
    end

    // Prefetch abort tag rides down the pipe with its instruction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dec_bad_q <= 1'b0;
            exe_bad_q <= 1'b0;
        end else if (flush) begin
            dec_bad_q <= 1'b0;
            exe_bad_q <= 1'b0;
        end else begin
            if (decode_adv)
                dec_bad_q <= fetch_abort;
            if (exec_adv)
                exe_bad_q <= dec_bad_q;
            else if (kind_d == xec_pkg::XEC_PABT)
                exe_bad_q <= 1'b0;
        end
    end

    // Priority resolution: precise data abort in any cycle, the rest at instruction end
    always_comb begin
        kind_d = xec_pkg::XEC_NONE;
        if (dabt_p)
            kind_d = xec_pkg::XEC_DABT_P;
        else if (instr_end && !f_q && !fiq_q)
            kind_d = xec_pkg::XEC_FIQ;
        else if (instr_end && !i_q && !irq_q)
            kind_d = xec_pkg::XEC_IRQ;
        else if (instr_end && !a_q && (pend_q || watch_q))
            kind_d = xec_pkg::XEC_DABT_I;
        else if (instr_end && exe_bad_q && !flush)
            kind_d = xec_pkg::XEC_PABT;
        else if (instr_end && exec_is_breakpoint_instr && !flush)
            kind_d = halt_debug_mode ? xec_pkg::XEC_DEBUG
                                     : xec_pkg::XEC_BREAKPOINT_INSTR;
        else if (instr_end && exec_is_undef)
            kind_d = xec_pkg::XEC_UNDEF;
        else if (instr_end && exec_is_svc)
            kind_d = xec_pkg::XEC_SVC;
    end

    // Pending imprecise abort; new arrival beats the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            pend_q <= 1'b0;
        else if (imp_err)
            pend_q <= 1'b1;
        else if (kind_d == xec_pkg::XEC_DABT_I)
            pend_q <= 1'b0;
    end

    // Watchpoint hit held until the boundary; freezes later memory ops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            watch_q <= 1'b0;
        else if (watch_hit)
            watch_q <= 1'b1;
        else if (kind_d == xec_pkg::XEC_DABT_I)
            watch_q <= 1'b0;
    end

    // Status masks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            f_q <= xec_pkg::MASK_RESET;
            i_q <= xec_pkg::MASK_RESET;
            a_q <= xec_pkg::MASK_RESET;
        end else begin
            case (kind_d)
                xec_pkg::XEC_FIQ: begin
                    f_q <= 1'b1;
                    i_q <= 1'b1;
                    a_q <= 1'b1;
                end
                xec_pkg::XEC_IRQ: begin
                    i_q <= 1'b1;
                    a_q <= 1'b1;
                end
                xec_pkg::XEC_DABT_P, xec_pkg::XEC_DABT_I,
                xec_pkg::XEC_PABT, xec_pkg::XEC_BREAKPOINT_INSTR: begin
                    i_q <= 1'b1;
                    a_q <= 1'b1;
                end
                xec_pkg::XEC_UNDEF, xec_pkg::XEC_SVC: begin
                    i_q <= 1'b1;
                end
                default: begin
                    if (sw_mask_we) begin
                        f_q <= sw_fast_mask;
                        i_q <= sw_normal_mask;
                        a_q <= sw_abort_mask;
                    end
                end
            endcase
        end
    end

    // Entry outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            take_q <= 1'b0;
            vec_q <= xec_pkg::VEC_BASE_LOW;
            kind_q <= 4'h0;
            fs_q <= xec_pkg::FS_NONE;
            rest_q <= 1'b0;
            dbg_q <= 1'b0;
        end else begin
            take_q <= (kind_d != xec_pkg::XEC_NONE)
                      && (kind_d != xec_pkg::XEC_DEBUG);
            dbg_q <= (kind_d == xec_pkg::XEC_DEBUG);
            kind_q <= kind_d;
            rest_q <= (kind_d == xec_pkg::XEC_DABT_P)
                      || (kind_d == xec_pkg::XEC_DABT_I);
            vec_q <= (vec_high_sel ? xec_pkg::VEC_BASE_HIGH
                                   : xec_pkg::VEC_BASE_LOW)
                     | {24'h00_0000, vofs(kind_d)};
            if (kind_d == xec_pkg::XEC_DABT_P)
                fs_q <= fs_p;
            else if (kind_d == xec_pkg::XEC_DABT_I)
                fs_q <= watch_q ? xec_pkg::FS_WATCH
                                : xec_pkg::FS_EXT_IMPRECISE;
        end
    end

    // Return address from link value
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            ret_q <= 32'h0000_0000;
        else if (ret_req) begin
            case (xec_pkg::xec_ret_e'(ret_kind))
                xec_pkg::XEC_RET_FIQ,
                xec_pkg::XEC_RET_IRQ_ABT:
                    ret_q <= link_value - xec_pkg::RET_SUB_4;
                xec_pkg::XEC_RET_DABT:
                    ret_q <= link_value - xec_pkg::RET_SUB_8;
                default:
                    ret_q <= link_value - xec_pkg::RET_SUB_0;
            endcase
        end
    end

    assign take_exc = take_q;
    assign vector_addr = vec_q;
    assign exc_kind = kind_q;
    assign fault_status = fs_q;
    assign base_restore = rest_q;
    assign debug_enter = dbg_q;
    assign return_pc = ret_q;
    assign fast_mask = f_q;
    assign normal_mask = i_q;
    assign abort_mask = a_q;
    assign abort_pending = pend_q;
    assign hold_mem = watch_q && next_is_mem;

    AST_FIQ_ENTRY_MASKS: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_FIQ |=> f_q && i_q && a_q)
        else $error("fast entry did not set masks");
    AST_FIQ_REGISTERED: assert property (
        @(posedge ref_clk) disable iff (rst)
        instr_end && !f_q && !fiq_q && !dabt_p |=> take_q
        && kind_q == 4'(xec_pkg::XEC_FIQ))
        else $error("fast request not taken");
    AST_FIQ_PIN_LAT: assert property (
        @(posedge ref_clk) disable iff (rst)
        fiq_q == $past(fast_irq_in_n))
        else $error("fast pin not registered");
    AST_IRQ_MASKED: assert property (
        @(posedge ref_clk) disable iff (rst)
        i_q && kind_d != xec_pkg::XEC_NONE |-> kind_d != xec_pkg::XEC_IRQ)
        else $error("masked normal request taken");
    AST_IRQ_KEEPS_F: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_IRQ |=> f_q == $past(f_q) && i_q)
        else $error("normal entry touched fast mask");
    AST_IRQ_SETS_A: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_IRQ |=> a_q)
        else $error("normal entry left abort mask clear");
    AST_IRQ_BELOW_FIQ: assert property (
        @(posedge ref_clk) disable iff (rst)
        instr_end && !f_q && !fiq_q |-> kind_d != xec_pkg::XEC_IRQ)
        else $error("normal request beat fast request");
    AST_PEND_HELD: assert property (
        @(posedge ref_clk) disable iff (rst)
        imp_err ##1 a_q [*2] |-> pend_q)
        else $error("imprecise abort lost");
    AST_PEND_STICKY: assert property (
        @(posedge ref_clk) disable iff (rst)
        pend_q && !imp_err && kind_d != xec_pkg::XEC_DABT_I |=> pend_q)
        else $error("pending abort dropped untaken");
    AST_UNREQ_IGNORED: assert property (
        @(posedge ref_clk) disable iff (rst)
        bus_resp_valid && bus_cacheable && !bus_word_requested
        && !mmu_fault && !coproc_abort |-> !imp_err && !dabt_p)
        else $error("unrequested word raised abort");
    AST_ABORT_MASKS: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_DABT_P || kind_d == xec_pkg::XEC_DABT_I
        || kind_d == xec_pkg::XEC_PABT || kind_d == xec_pkg::XEC_BREAKPOINT_INSTR
        |=> i_q && a_q)
        else $error("abort entry left masks clear");
    AST_SVC_MASKS: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_SVC |=> i_q && a_q == $past(a_q))
        else $error("supervisor call masks wrong");
    AST_UNDEF_MASKS: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_UNDEF |=> i_q && f_q == $past(f_q))
        else $error("undefined entry masks wrong");
    AST_PABT_ONCE: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_PABT && !exec_adv
        |=> kind_d != xec_pkg::XEC_PABT)
        else $error("prefetch abort taken twice");
    AST_DBG_NO_TAKE: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_DEBUG |=> dbg_q && !take_q)
        else $error("debug entry also took abort");
    AST_VEC_FIQ: assert property (
        @(posedge ref_clk) disable iff (rst)
        kind_d == xec_pkg::XEC_FIQ && vec_high_sel |=>
        vec_q == 32'hffff_001c)
        else $error("wrong fast vector");
    AST_DABT_RET: assert property (
        @(posedge ref_clk) disable iff (rst)
        ret_req && ret_kind == 2'h3 |=> ret_q == $past(link_value) - 32'h8)
        else $error("wrong data abort return");
    AST_FLUSH_DROP: assert property (
        @(posedge ref_clk) disable iff (rst)
        flush |=> !exe_bad_q)
        else $error("flushed abort kept");
    AST_PRECISE_FIRST: assert property (
        @(posedge ref_clk) disable iff (rst)
        dabt_p |=> kind_q == 4'(xec_pkg::XEC_DABT_P) && rest_q)
        else $error("precise abort not first");
    COV_FIQ: cover property (@(posedge ref_clk) kind_d == xec_pkg::XEC_FIQ);
    COV_IMP: cover property (@(posedge ref_clk) kind_d == xec_pkg::XEC_DABT_I);
    COV_PABT: cover property (@(posedge ref_clk) kind_d == xec_pkg::XEC_PABT);
    COV_DBG: cover property (@(posedge ref_clk) kind_d == xec_pkg::XEC_DEBUG);
endmodule
`default_nettype wire

// file: sim/xec_entry_tb.sv
`timescale 1ns/1ns
`default_nettype none
module xec_entry_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic instr_end = 1'b1, vec_high_sel = 1'b0, halt_debug_mode = 1'b0;
    logic sw_fast_mask = 1'b1, sw_normal_mask = 1'b1, sw_abort_mask = 1'b1;
    logic next_is_mem = 1'b0;
    logic [2:0] mmu_fault_kind = 3'h0;
    logic [31:0] link_value = 32'h0;
    logic [1:0] ret_kind = 2'h0;
    logic [11:0] pv = 12'h000;
    logic sw_mask_we, ret_req, watch_hit, coproc_abort, mmu_fault, flush;
    logic exec_is_undef, exec_is_svc, exec_is_breakpoint_instr, exec_adv, decode_adv;
    logic fetch_abort, fast_irq_in_n, normal_irq_in_n, bus_resp_valid;
    logic bus_ordered, bus_load_pc_status, bus_swap_load, bus_cacheable;
    logic bus_word_requested, take_exc, fast_mask, normal_mask, abort_mask;
    logic base_restore, abort_pending, debug_enter, hold_mem;
    logic [1:0] bus_resp;
    logic [31:0] vector_addr, return_pc;
    logic [3:0] exc_kind;
    logic [4:0] fault_status;
    int n_errors = 0;
    int n_checks = 0;
    assign {sw_mask_we, ret_req, watch_hit, coproc_abort, mmu_fault,
        exec_is_undef, exec_is_svc, exec_is_breakpoint_instr, flush, exec_adv,
        decode_adv, fetch_abort} = pv;
    xec_far_end u_far (.ref_clk, .fast_irq_in_n, .normal_irq_in_n,
        .bus_resp_valid, .bus_resp, .bus_ordered, .bus_load_pc_status,
        .bus_swap_load, .bus_cacheable, .bus_word_requested);
    xec_entry u_dut (.ref_clk, .rst, .fast_irq_in_n, .normal_irq_in_n,
        .instr_end, .vec_high_sel, .halt_debug_mode, .sw_mask_we,
        .sw_fast_mask, .sw_normal_mask, .sw_abort_mask, .fetch_abort,
        .decode_adv, .exec_adv, .flush, .exec_is_breakpoint_instr, .exec_is_svc,
        .exec_is_undef, .mmu_fault, .mmu_fault_kind, .coproc_abort,
        .watch_hit, .next_is_mem, .bus_resp_valid, .bus_resp, .bus_ordered,
        .bus_load_pc_status, .bus_swap_load, .bus_cacheable,
        .bus_word_requested, .link_value, .ret_kind, .ret_req, .take_exc,
        .vector_addr, .exc_kind, .fast_mask, .normal_mask, .abort_mask,
        .fault_status, .base_restore, .abort_pending, .debug_enter,
        .return_pc, .hold_mem);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(input logic [11:0] v);
        @(posedge ref_clk);
        pv <= v;
        @(posedge ref_clk);
        pv <= 12'h000;
    endtask
    task automatic masks(input logic f, input logic n, input logic a);
        @(posedge ref_clk);
        {sw_fast_mask, sw_normal_mask, sw_abort_mask} <= {f, n, a};
        pv <= 12'h800;
        @(posedge ref_clk);
        pv <= 12'h000;
    endtask
    task automatic expect_take(input logic [3:0] kind, input logic [7:0] ofs);
        logic [31:0] base;
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            if (take_exc === 1'b1) break;
        end
        base = vec_high_sel ? xec_pkg::VEC_BASE_HIGH : xec_pkg::VEC_BASE_LOW;
        check("take_exc", take_exc, 1'b1);
        check("exc_kind", exc_kind, kind);
        check("vector_addr", vector_addr, base | {24'h0, ofs});
    endtask
    task automatic expect_none(input int n);
        int hits = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (take_exc !== 1'b0) hits++;
        end
        check("no take", hits, 0);
    endtask
    task automatic settle();
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic t_irq();
        check("reset masks", {fast_mask, normal_mask, abort_mask}, 3'h7);
        check("pending", abort_pending, 1'b0);
        masks(1'b0, 1'b0, 1'b0);
        instr_end <= 1'b0;
        vec_high_sel <= 1'b1;
        u_far.set_irq(1'b0, 1'b0);
        expect_none(4);
        @(posedge ref_clk);
        instr_end <= 1'b1;
        expect_take(xec_pkg::XEC_FIQ, xec_pkg::VOFS_FIQ);
        settle();
        check("masks", {fast_mask, normal_mask, abort_mask}, 3'h7);
        expect_none(3);
        u_far.set_irq(1'b1, 1'b1);
        masks(1'b0, 1'b0, 1'b0);
        vec_high_sel <= 1'b0;
        u_far.set_irq(1'b1, 1'b0);
        expect_take(xec_pkg::XEC_IRQ, xec_pkg::VOFS_IRQ);
        settle();
        check("masks", {fast_mask, normal_mask, abort_mask}, 3'h3);
        expect_none(4);
        u_far.set_irq(1'b1, 1'b1);
        $display("test interrupts done");
    endtask
    task automatic t_return();
        logic [1:0] k[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [31:0] s[4] = '{xec_pkg::RET_SUB_4, xec_pkg::RET_SUB_4,
            xec_pkg::RET_SUB_8, xec_pkg::RET_SUB_0};
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            ret_kind <= k[i];
            link_value <= 32'h0000_2000 + 32'(i);
            pv <= 12'h400;
            @(posedge ref_clk);
            pv <= 12'h000;
            @(negedge ref_clk);
            check("return_pc", return_pc, 32'h0000_2000 + 32'(i) - s[i]);
        end
        $display("test return done");
    endtask
    task automatic t_dabt();
        logic [2:0] mk[4] = '{xec_pkg::MF_ALIGN, xec_pkg::MF_TRANS,
            xec_pkg::MF_DOMAIN, xec_pkg::MF_PERM};
        logic [4:0] fs[5] = '{xec_pkg::FS_ALIGN, xec_pkg::FS_TRANS,
            xec_pkg::FS_DOMAIN, xec_pkg::FS_PERM, xec_pkg::FS_COPROC};
        for (int i = 0; i < 5; i++) begin
            masks(1'b0, 1'b0, 1'b1);
            mmu_fault_kind <= mk[i % 4];
            pulse(i == 4 ? 12'h100 : 12'h080);
            expect_take(xec_pkg::XEC_DABT_P, xec_pkg::VOFS_DABT);
            check("fault_status", fault_status, fs[i]);
            check("base_restore", base_restore, 1'b1);
            settle();
            check("normal_mask", normal_mask, 1'b1);
        end
        $display("test precise aborts done");
    endtask
    task automatic t_ext();
        logic [4:0] q[3] = '{5'b10001, 5'b01001, 5'b00101};
        masks(1'b0, 1'b0, 1'b1);
        u_far.respond(xec_pkg::RESP_SLVERR, 5'b00011);
        expect_none(3);
        check("pending", abort_pending, 1'b1);
        masks(1'b0, 1'b0, 1'b0);
        expect_take(xec_pkg::XEC_DABT_I, xec_pkg::VOFS_DABT);
        check("fault_status", fault_status, xec_pkg::FS_EXT_IMPRECISE);
        settle();
        check("pending", abort_pending, 1'b0);
        check("abort_mask", abort_mask, 1'b1);
        u_far.respond(xec_pkg::RESP_DECERR, 5'b10010);
        expect_none(4);
        check("pending", abort_pending, 1'b0);
        for (int i = 0; i < 3; i++) begin
            u_far.respond(xec_pkg::RESP_DECERR, q[i]);
            expect_take(xec_pkg::XEC_DABT_P, xec_pkg::VOFS_DABT);
            check("fault_status", fault_status, xec_pkg::FS_EXT_PRECISE);
        end
        masks(1'b0, 1'b0, 1'b0);
        next_is_mem <= 1'b1;
        pulse(12'h200);
        @(negedge ref_clk);
        check("hold_mem", hold_mem, 1'b1);
        expect_take(xec_pkg::XEC_DABT_I, xec_pkg::VOFS_DABT);
        check("fault_status", fault_status, xec_pkg::FS_WATCH);
        check("hold_mem", hold_mem, 1'b0);
        $display("test external aborts done");
    endtask
    task automatic t_sync();
        int hit = 0;
        pulse(12'h003);
        pulse(12'h008);
        pulse(12'h004);
        expect_none(4);
        pulse(12'h003);
        pulse(12'h004);
        expect_take(xec_pkg::XEC_PABT, xec_pkg::VOFS_PABT);
        pulse(12'h008);
        pulse(12'h014);
        expect_take(xec_pkg::XEC_BREAKPOINT_INSTR, xec_pkg::VOFS_PABT);
        @(posedge ref_clk);
        halt_debug_mode <= 1'b1;
        pulse(12'h014);
        for (int i = 0; i < 8 && hit == 0; i++) begin
            @(negedge ref_clk);
            if (debug_enter === 1'b1) hit = 1;
        end
        check("debug_enter", hit, 1);
        check("take on debug", take_exc, 1'b0);
        @(posedge ref_clk);
        halt_debug_mode <= 1'b0;
        masks(1'b0, 1'b0, 1'b0);
        pulse(12'h020);
        expect_take(xec_pkg::XEC_SVC, xec_pkg::VOFS_SVC);
        settle();
        check("masks", {fast_mask, normal_mask, abort_mask}, 3'h2);
        masks(1'b0, 1'b0, 1'b0);
        pulse(12'h040);
        expect_take(xec_pkg::XEC_UNDEF, xec_pkg::VOFS_UNDEF);
        settle();
        check("masks", {fast_mask, normal_mask, abort_mask}, 3'h2);
        $display("test instruction exceptions done");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #80000;
        n_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        t_irq();
        t_return();
        t_dabt();
        t_ext();
        t_sync();
        print_verdict();
    end
endmodule
`default_nettype wire

// file: sim/xec_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module xec_far_end (
    input wire logic ref_clk,
    output logic fast_irq_in_n,
    output logic normal_irq_in_n,
    output logic bus_resp_valid,
    output logic [1:0] bus_resp,
    output logic bus_ordered,
    output logic bus_load_pc_status,
    output logic bus_swap_load,
    output logic bus_cacheable,
    output logic bus_word_requested
);
    initial begin
        fast_irq_in_n = 1'b1;
        normal_irq_in_n = 1'b1;
        bus_resp_valid = 1'b0;
        bus_resp = 2'h0;
        {bus_ordered, bus_load_pc_status, bus_swap_load} = 3'h0;
        {bus_cacheable, bus_word_requested} = 2'h0;
    end
    // Requests are levels held until the handler clears the source
    task automatic set_irq(input logic f_n, input logic n_n);
        @(posedge ref_clk);
        fast_irq_in_n <= f_n;
        normal_irq_in_n <= n_n;
    endtask
    // Qualifiers flip once valid drops, so nothing may lean on stale values
    task automatic respond(input logic [1:0] resp, input logic [4:0] q);
        @(posedge ref_clk);
        bus_resp_valid <= 1'b1;
        bus_resp <= resp;
        {bus_ordered, bus_load_pc_status, bus_swap_load, bus_cacheable,
            bus_word_requested} <= q;
        @(posedge ref_clk);
        bus_resp_valid <= 1'b0;
        bus_resp <= ~resp;
        {bus_ordered, bus_load_pc_status, bus_swap_load, bus_cacheable,
            bus_word_requested} <= ~q;
    endtask
endmodule
`default_nettype wire
